// [hdl/rip_pkg.sv]
package rip_pkg;
  localparam int unsigned CLK_MHZ          = 100;
  // minimum low time on the reset input, in ns, before it counts as a reset
  localparam int unsigned RST_IN_MIN_NS    = 100;
  localparam int unsigned RST_IN_MIN_CYC   = (RST_IN_MIN_NS * CLK_MHZ + 999) / 1000;
  // internal reset sequence length in cycles
  localparam int unsigned RST_SEQ_CYC      = 16;
  localparam int unsigned CNT_W            = 8;
  localparam int unsigned BOOT_BIT         = 4;
  localparam int unsigned P0L_W            = 8;

  localparam logic [1:0] IRQ_NMI_BIT  = 2'h0;
  localparam logic [1:0] IRQ_PD_BIT   = 2'h1;
  localparam logic [1:0] IRQ_IGN_BIT  = 2'h2;
  localparam int unsigned IRQ_W       = 3;

  localparam logic [3:0] ADDR_CTRL    = 4'h0;
  localparam logic [3:0] ADDR_STAT    = 4'h1;
  localparam logic [3:0] ADDR_IRQ     = 4'h2;
  localparam logic [3:0] ADDR_MASK    = 4'h3;

  typedef enum logic [1:0] {
    RIP_RUN   = 2'b00,
    RIP_RESET = 2'b01,
    RIP_INIT  = 2'b10,
    RIP_PDOWN = 2'b11
  } rip_state_e;

  typedef struct packed {
    logic sw_reset;
    logic wdt_reset;
    logic end_init;
    logic power_down;
  } rip_cpu_s;
endpackage : rip_pkg

// [hdl/rip_ctrl.sv]
// Contract
// [R1] reset output low during any reset
// [R2] reset output low until end-init executes
// [R3] nmi falling edge requests trap vector
// [R4] power-down with nmi low enters power down
// [R5] power-down with nmi high is ignored
// [R6] bidir enable locked after end-init
// [R7] every reset clears bidir enable
// [R8] bidir active keeps watchdog flag zero
// [R9] bidir active latches port zero config
// [R10] bidir pulls reset pin during sequence
// [R11] external logic holds reset low long enough
// [R12] nmi synchronised, sampled at power-down
//
// Chosen here: strobed register access and the placing of the registers.
module rip_ctrl
  import rip_pkg::*;
#(
  parameter int unsigned SEQ_CYC = RST_SEQ_CYC
) (
  input  wire logic              CLK_SYS,
  input  wire logic              SRST,
  input  wire rip_cpu_s          CPU_EVT,
  input  wire logic              NMI_N,
  input  wire logic              RST_IN_N_I,
  output logic                   RST_IN_N_O,
  output logic                   RST_IN_N_OE_N,
  input  wire logic [P0L_W-1:0]  P0L_I,
  input  wire logic [3:0]        ADDR,
  input  wire logic [7:0]        WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic [7:0]             RDATA,
  output logic                   RESET_INDICATION_OUT,
  output logic                   CPU_RESET,
  output logic                   NMI_TRAP,
  output logic                   POWER_DOWN,
  output logic                   BOOT_LOADER,
  output logic                   IRQ
);

  rip_state_e           state_ff,    nxt_state;
  logic [CNT_W-1:0]     cnt_ff,      nxt_cnt;
  logic [CNT_W-1:0]     rin_cnt_ff;
  logic [1:0]           nmi_sync_ff;
  logic [1:0]           rin_sync_ff;
  logic                 nmi_prev_ff;
  logic                 bidir_reset_enable_ff;
  logic                 watchdog_reset_flag_ff;
  logic                 init_done_ff;
  logic                 seq_bidir_ff;
  logic                 drive_pin_ff;
  logic [P0L_W-1:0]     port_zero_cfg_ff;
  logic [IRQ_W-1:0]     irq_stat_ff;
  logic [IRQ_W-1:0]     irq_mask_ff;
  logic [7:0]           rdata_ff;
  logic                 trap_ff;

  wire nmi_lvl      = nmi_sync_ff[1];
  wire rin_low      = ~rin_sync_ff[1];
  wire nmi_fall     = nmi_prev_ff & ~nmi_lvl;                    // [R3]
  wire soft_reset   = CPU_EVT.sw_reset | CPU_EVT.wdt_reset;
  // only count external pulses we did not cause ourselves
  wire ext_reset    = rin_low & ~drive_pin_ff
                      & (rin_cnt_ff >= CNT_W'(RST_IN_MIN_CYC - 1)); // [R11]
  wire any_reset    = ext_reset | (soft_reset & (state_ff != RIP_RESET));
  wire running      = (state_ff == RIP_RUN) | (state_ff == RIP_INIT);
  wire pd_take      = running & CPU_EVT.power_down & ~nmi_lvl;    // [R4] [R12]
  wire pd_ignored   = running & CPU_EVT.power_down & nmi_lvl;     // [R5]
  wire wr_ctrl      = WR & (ADDR == ADDR_CTRL);
  wire wr_irq       = WR & (ADDR == ADDR_IRQ);
  wire wr_mask      = WR & (ADDR == ADDR_MASK);
  wire ctrl_change  = wr_ctrl & ~init_done_ff;                    // [R6]
  wire seq_end      = (state_ff == RIP_RESET) & (cnt_ff == '0);
  wire [IRQ_W-1:0] irq_evt;
  wire [7:0]       rd_mux;

  assign irq_evt[IRQ_NMI_BIT] = nmi_fall;
  assign irq_evt[IRQ_PD_BIT]  = pd_take;
  assign irq_evt[IRQ_IGN_BIT] = pd_ignored;

  assign rd_mux =
    (ADDR == ADDR_CTRL) ? {7'h00, bidir_reset_enable_ff} :
    (ADDR == ADDR_STAT) ? {2'h0, state_ff, port_zero_cfg_ff[BOOT_BIT],
                           init_done_ff, watchdog_reset_flag_ff, nmi_lvl} :
    (ADDR == ADDR_IRQ)  ? {5'h00, irq_stat_ff} :
    (ADDR == ADDR_MASK) ? {5'h00, irq_mask_ff} : 8'h00;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    unique case (state_ff)
      RIP_RESET: begin
        if (cnt_ff != '0) begin
          nxt_cnt = cnt_ff - 1'b1;
        end else begin
          nxt_state = RIP_INIT;
        end
      end
      RIP_INIT: begin
        if (CPU_EVT.end_init) begin
          nxt_state = RIP_RUN;                                    // [R2]
        end
      end
      RIP_RUN: begin
      end
      RIP_PDOWN: begin
        // only a reset leaves power down
      end
    endcase
    if (pd_take) begin
      nxt_state = RIP_PDOWN;
    end
    if (any_reset) begin
      nxt_state = RIP_RESET;
      nxt_cnt   = CNT_W'(SEQ_CYC - 1);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    nmi_sync_ff <= {nmi_sync_ff[0], NMI_N};                       // [R12]
    rin_sync_ff <= {rin_sync_ff[0], RST_IN_N_I};
    if (SRST) begin
      state_ff    <= RIP_RESET;
      cnt_ff      <= CNT_W'(SEQ_CYC - 1);
      nmi_prev_ff <= 1'b1;
      rin_cnt_ff  <= '0;
    end else begin
      state_ff    <= nxt_state;
      cnt_ff      <= nxt_cnt;
      nmi_prev_ff <= nmi_lvl;
      // our own pull on the pin must never age into an external reset
      rin_cnt_ff  <= (rin_low & ~drive_pin_ff) ?
                     ((rin_cnt_ff == '1) ? rin_cnt_ff : rin_cnt_ff + 1'b1) : '0; // [R10] [R11]
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      bidir_reset_enable_ff <= 1'b0;
      init_done_ff          <= 1'b0;
      watchdog_reset_flag_ff <= 1'b0;
      seq_bidir_ff          <= 1'b0;
      drive_pin_ff          <= 1'b0;
    end else if (any_reset) begin
      bidir_reset_enable_ff <= 1'b0;                              // [R7]
      init_done_ff          <= 1'b0;
      // remember the mode that was active when this reset began
      seq_bidir_ff          <= bidir_reset_enable_ff;
      watchdog_reset_flag_ff <= CPU_EVT.wdt_reset & ~bidir_reset_enable_ff; // [R8]
      drive_pin_ff          <= soft_reset & ~ext_reset & bidir_reset_enable_ff; // [R10]
    end else begin
      if (ctrl_change) begin
        bidir_reset_enable_ff <= WDATA[0];                        // [R6]
      end
      if (state_ff == RIP_INIT && CPU_EVT.end_init) begin
        init_done_ff <= 1'b1;
      end
      if (seq_end) begin
        drive_pin_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      port_zero_cfg_ff <= '0;
    end else if (seq_end && (rin_low || seq_bidir_ff)) begin
      // hardware reset, or bidir reset treated as one
      port_zero_cfg_ff <= P0L_I;                                  // [R9]
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      irq_stat_ff <= '0;
      irq_mask_ff <= '0;
      rdata_ff    <= 8'h00;
      trap_ff     <= 1'b0;
    end else begin
      // set wins over a write-one clear in the same cycle
      irq_stat_ff <= (irq_stat_ff & ~(wr_irq ? WDATA[IRQ_W-1:0] : '0)) | irq_evt;
      if (wr_mask) begin
        irq_mask_ff <= WDATA[IRQ_W-1:0];
      end
      rdata_ff <= RD ? rd_mux : 8'h00;
      trap_ff  <= nmi_fall & running;                             // [R3]
    end
  end

  // power down taken before end-init must not release the indication
  assign RESET_INDICATION_OUT = init_done_ff;                     // [R1] [R2]
  assign CPU_RESET            = (state_ff == RIP_RESET);
  assign RST_IN_N_O           = 1'b0;
  assign RST_IN_N_OE_N        = ~drive_pin_ff;                    // [R10]
  assign NMI_TRAP             = trap_ff;
  assign POWER_DOWN           = (state_ff == RIP_PDOWN);
  assign BOOT_LOADER          = ~port_zero_cfg_ff[BOOT_BIT];      // [R9]
  assign RDATA                = rdata_ff;
  assign IRQ                  = |(irq_stat_ff & irq_mask_ff);

endmodule : rip_ctrl

// [dv/rip_far.sv]
module rip_far (
  input  wire logic oe_n,
  input  wire logic ext_low,
  output logic      pin_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // open-drain line with pull-up: low if either side pulls
  assign pin_n = oe_n & !ext_low;
endmodule : rip_far

// [dv/rip_ctrl_checker.sv]
module rip_chk
  import rip_pkg::*;
(
  input wire logic     CLK_SYS,
  input wire logic     SRST,
  input wire rip_cpu_s CPU_EVT,
  input wire logic     NMI_N,
  input wire logic     RST_IN_N_OE_N,
  input wire logic     RESET_INDICATION_OUT,
  input wire logic     CPU_RESET,
  input wire logic     NMI_TRAP,
  input wire logic     POWER_DOWN,
  input wire logic     BOOT_LOADER
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SRST);
  ind_rst_low_a: assert property (CPU_RESET |-> !RESET_INDICATION_OUT)
    else $error("ind high in reset");
  ind_by_init_a: assert property ($rose(RESET_INDICATION_OUT) |-> $past(CPU_EVT.end_init))
    else $error("ind rose without end init");
  pd_enter_a: assert property ((!NMI_N)[*4] ##0 (CPU_EVT.power_down && RESET_INDICATION_OUT)
    |=> POWER_DOWN)
    else $error("power down not entered");
  pd_ignore_a: assert property (NMI_N[*4] ##0 (CPU_EVT.power_down && !POWER_DOWN)
    |=> !POWER_DOWN)
    else $error("power down not ignored");
  nmi_trap_a: assert property (RESET_INDICATION_OUT && !POWER_DOWN && $fell(NMI_N)
    |-> ##[1:5] NMI_TRAP)
    else $error("no trap after nmi edge");
  trap_pulse_a: assert property (NMI_TRAP |=> !NMI_TRAP)
    else $error("trap longer than one cycle");
  pin_pull_a: assert property (!RST_IN_N_OE_N |-> CPU_RESET || $past(CPU_RESET))
    else $error("pin pulled outside sequence");
  boot_latch_a: assert property ($changed(BOOT_LOADER) |-> CPU_RESET || $past(CPU_RESET))
    else $error("boot select changed outside reset");
  cover property (POWER_DOWN);
  cover property (NMI_TRAP);
  cover property (!RST_IN_N_OE_N);
endmodule : rip_chk
bind rip_ctrl rip_chk u_chk (.CLK_SYS(CLK_SYS), .SRST(SRST), .CPU_EVT(CPU_EVT),
  .NMI_N(NMI_N), .RST_IN_N_OE_N(RST_IN_N_OE_N), .RESET_INDICATION_OUT(RESET_INDICATION_OUT),
  .CPU_RESET(CPU_RESET), .NMI_TRAP(NMI_TRAP), .POWER_DOWN(POWER_DOWN),
  .BOOT_LOADER(BOOT_LOADER));

// [dv/tb_top.sv]
module tb_top
  import rip_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 0, srst = 1, nmi_n = 1, wr = 0, rd = 0, ext_low = 0;
  logic       oe_n, pin_n, ind, cpu_rst, trap, pdn, boot, irq;
  logic [3:0] addr = '0;
  logic [7:0] wdata = '0, p0l = 8'hff, rdata;
  rip_cpu_s   evt = '0;
  int         fails = 0, n_checks = 0;
  rip_ctrl #(.SEQ_CYC(4)) dut (.CLK_SYS(clk), .SRST(srst), .CPU_EVT(evt), .NMI_N(nmi_n),
    .RST_IN_N_I(pin_n), .RST_IN_N_O(), .RST_IN_N_OE_N(oe_n), .P0L_I(p0l), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .RESET_INDICATION_OUT(ind),
    .CPU_RESET(cpu_rst), .NMI_TRAP(trap), .POWER_DOWN(pdn), .BOOT_LOADER(boot), .IRQ(irq));
  rip_far far (.oe_n(oe_n), .ext_low(ext_low), .pin_n(pin_n));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic bus(logic w, logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    {wr, rd, addr, wdata} <= {w, !w, a, d};
    @(posedge clk);
    {wr, rd} <= 2'b00;
    #1;
  endtask : bus
  task automatic ev(logic [3:0] v);
    @(posedge clk);
    evt <= rip_cpu_s'(v);
    @(posedge clk);
    evt <= '0;
    repeat (2) @(posedge clk);
    #1;
  endtask : ev
  // bounded wait so a stuck sequence ends in a mismatch, not a hang
  task automatic wt;
    repeat (40) if (cpu_rst !== 1'b0) @(posedge clk);
    #1;
  endtask : wt
  task automatic t_boot;
    wt();
    chk("ind", 0, ind);
    bus(1, ADDR_CTRL, 8'h01);
    ev(4'h2);
    chk("ind", 1, ind);
    bus(1, ADDR_CTRL, 8'h00);
    bus(0, ADDR_CTRL, 8'h00);
    chk("ctrl", 1, rdata);
  endtask : t_boot
  task automatic t_sw;
    p0l <= 8'h10;
    ev(4'h8);
    chk("ind", 0, ind);
    chk("oe_n", 0, oe_n);
    wt();
    chk("ind", 0, ind);
    chk("boot", 0, boot);
    bus(0, ADDR_CTRL, 8'h00);
    chk("ctrl", 0, rdata);
  endtask : t_sw
  task automatic t_wdt;
    bus(1, ADDR_CTRL, 8'h01);
    ev(4'h4);
    wt();
    bus(0, ADDR_STAT, 8'h00);
    chk("wdt_flag", 0, rdata[1]);
    ev(4'h2);
  endtask : t_wdt
  task automatic t_nmi;
    bus(1, ADDR_MASK, 8'h07);
    nmi_n <= 1'b0;
    repeat (6) @(posedge clk);
    bus(0, ADDR_IRQ, 8'h00);
    chk("irq_st", 8'h01, rdata);
    bus(1, ADDR_IRQ, 8'h01);
    chk("irq", 0, irq);
  endtask : t_nmi
  task automatic t_pd;
    nmi_n <= 1'b1;
    repeat (6) @(posedge clk);
    ev(4'h1);
    chk("pdn", 0, pdn);
    chk("irq", 1, irq);
    nmi_n <= 1'b0;
    repeat (6) @(posedge clk);
    ev(4'h1);
    chk("pdn", 1, pdn);
  endtask : t_pd
  task automatic t_pin;
    ext_low <= 1'b1;
    repeat (16) @(posedge clk);
    ext_low <= 1'b0;
    #1;
    chk("ind", 0, ind);
    chk("pdn", 0, pdn);
  endtask : t_pin
  task automatic give_verdict;
    if (fails == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_boot();
    t_sw();
    t_wdt();
    t_nmi();
    t_pd();
    t_pin();
    give_verdict();
  end
  initial begin
    #20us;
    fails++;
    give_verdict();
  end
endmodule : tb_top
